/* File: core/fbp_port.sv */
/*
 Four-pin general-purpose port with APB register access, one interrupt input hand-off
 and two PWM output hand-offs.
 Assumes PWM signals come from timers on pclk; pins are asynchronous and are synchronised here.
*/
`timescale 1ns/10ps
module fbp_port
    import fbp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    input wire logic pwm_a_in,
    input wire logic pwm_b_in,
    output logic ext_irq_out
);

    // The decoder compares against 8-bit offsets
    if (ADDR_W < 8) begin : g_chk
        $error("fbp_port: ADDR_W must be at least 8");
    end

    typedef struct packed {
        logic [3:0] data_reg;
        logic [3:0] dir_reg;
        logic [3:0] func_reg;
        logic [3:0] sync1_reg;
        logic [3:0] sync2_reg;
        logic [7:0] rdata_reg;
        logic err_reg;
        logic [3:0] out_reg;
        logic [3:0] oe_reg;
        logic irq_reg;
    } fbp_state_t;

    fbp_state_t st_reg;
    fbp_state_t st_next;

    // Map a byte address onto a register index; anything else is unmapped
    function automatic logic [1:0] fbp_decode(input logic [ADDR_W-1:0] addr);
        logic [1:0] idx;
        idx = FBP_IDX_NONE;
        // A shift rather than a part-select, so the default width of 8 has no empty range
        if ((addr >> 8) == '0) begin
            case (addr[7:0])
                FBP_OFF_DATA: idx = FBP_IDX_DATA;
                FBP_OFF_DIR: idx = FBP_IDX_DIR;
                FBP_OFF_FUNC: idx = FBP_IDX_FUNC;
                default: idx = FBP_IDX_NONE;
            endcase
        end
        return idx;
    endfunction

    logic setup_ph;
    logic write_ph;
    logic [1:0] sel_idx;
    logic [3:0] gpio_own;

    // Zero-wait slave: read data is captured in setup and stands through access
    assign pready = 1'b1;
    assign setup_ph = psel && !penable;
    assign write_ph = psel && penable && pwrite;
    assign sel_idx = fbp_decode(paddr);

    // A pin is general-purpose unless its alternate function is selected
    always_comb begin
        gpio_own = 4'hF;
        gpio_own[FBP_PIN_PWM_A] = !st_reg.func_reg[FBP_FN_PWM_A];
        gpio_own[FBP_PIN_PWM_B] = !st_reg.func_reg[FBP_FN_PWM_B];
        gpio_own[FBP_PIN_IRQ] = !st_reg.func_reg[FBP_FN_IRQ];
    end

    // Next-state logic for the whole block
    always_comb begin
        st_next = st_reg;
        // Two flops before anything looks at the pins
        st_next.sync1_reg = pin_in;
        st_next.sync2_reg = st_reg.sync1_reg;

        // Writes land at the access edge; upper data bits are not stored at all
        if (write_ph) begin
            case (sel_idx)
                FBP_IDX_DATA: st_next.data_reg = pwdata[3:0];
                FBP_IDX_DIR: st_next.dir_reg = pwdata[3:0];
                FBP_IDX_FUNC: st_next.func_reg = pwdata[3:0];
                default: st_next.func_reg = st_reg.func_reg;
            endcase
        end

        // Read data and error flag are prepared during the setup cycle
        if (setup_ph) begin
            st_next.err_reg = (sel_idx == FBP_IDX_NONE);
            case (sel_idx)
                FBP_IDX_DATA: begin
                    // Output pins read the latch, input pins read the pin
                    st_next.rdata_reg = {FBP_UPPER_ONES,
                        (st_reg.data_reg & st_reg.dir_reg) |
                        (st_reg.sync2_reg & ~st_reg.dir_reg)};
                end
                FBP_IDX_DIR: st_next.rdata_reg = FBP_DIR_READ;
                FBP_IDX_FUNC: st_next.rdata_reg = {FBP_UPPER_ONES, st_reg.func_reg};
                default: st_next.rdata_reg = 8'h00;
            endcase
        end

        // Pin drivers: port settings apply only to general-purpose pins
        st_next.oe_reg = st_reg.dir_reg & gpio_own;
        st_next.out_reg = st_reg.data_reg & gpio_own;
        st_next.oe_reg[FBP_PIN_PLAIN] = st_reg.dir_reg[FBP_PIN_PLAIN];
        st_next.out_reg[FBP_PIN_PLAIN] = st_reg.data_reg[FBP_PIN_PLAIN];
        if (st_reg.func_reg[FBP_FN_PWM_A]) begin
            st_next.oe_reg[FBP_PIN_PWM_A] = 1'b1;
            st_next.out_reg[FBP_PIN_PWM_A] = pwm_a_in;
        end
        if (st_reg.func_reg[FBP_FN_PWM_B]) begin
            st_next.oe_reg[FBP_PIN_PWM_B] = 1'b1;
            st_next.out_reg[FBP_PIN_PWM_B] = pwm_b_in;
        end
        // Interrupt mode keeps the driver off even if software breaks the
        // direction restriction, so the board signal is never fought
        st_next.irq_reg = st_reg.func_reg[FBP_FN_IRQ] && st_reg.sync2_reg[FBP_PIN_IRQ];
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.data_reg <= FBP_DATA_RST;
            st_reg.dir_reg <= FBP_DIR_RST;
            st_reg.func_reg <= FBP_FUNC_RST;
            st_reg.sync1_reg <= 4'h0;
            st_reg.sync2_reg <= 4'h0;
            st_reg.rdata_reg <= 8'h00;
            st_reg.err_reg <= 1'b0;
            st_reg.out_reg <= 4'h0;
            st_reg.oe_reg <= 4'h0;
            st_reg.irq_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops; the upper 24 bits of read data are zero
    assign prdata = {24'h000000, st_reg.rdata_reg};
    assign pslverr = st_reg.err_reg;
    assign pin_out = st_reg.out_reg;
    assign pin_oe = st_reg.oe_reg;
    assign ext_irq_out = st_reg.irq_reg;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Setup then access of a read to a given register
    sequence s_read_data;
        psel && !penable && !pwrite && sel_idx == FBP_IDX_DATA ##1 psel && penable;
    endsequence
    sequence s_read_dir;
        psel && !penable && !pwrite && sel_idx == FBP_IDX_DIR ##1 psel && penable;
    endsequence

    a_data_upper_ones: assert property (s_read_data |-> prdata[7:4] == 4'hF)
        else $error("data read upper bits not all ones");
    a_data_out_bits: assert property (s_read_data |->
            (prdata[3:0] & $past(st_reg.dir_reg)) == ($past(st_reg.data_reg) & $past(st_reg.dir_reg)))
        else $error("output pin did not read stored value");
    a_data_in_bits: assert property (s_read_data |->
            (prdata[3:0] & ~$past(st_reg.dir_reg)) == ($past(st_reg.sync2_reg) & ~$past(st_reg.dir_reg)))
        else $error("input pin did not read pin level");
    a_dir_reads_ones: assert property (s_read_dir |-> prdata == 32'h000000FF)
        else $error("direction read not all ones");
    a_gpio_drive: assert property (!st_reg.func_reg[FBP_FN_PWM_A] |=>
            pin_oe[0] == $past(st_reg.dir_reg[0]) && (!pin_oe[0] || pin_out[0] == $past(st_reg.data_reg[0])))
        else $error("pin 0 general-purpose drive wrong");
    a_irq_no_drive: assert property (st_reg.func_reg[FBP_FN_IRQ] |=>
            !pin_oe[2] && ext_irq_out == $past(st_reg.sync2_reg[2]))
        else $error("interrupt pin driven or not routed");
    a_pwm_a_route: assert property (st_reg.func_reg[FBP_FN_PWM_A] |=>
            pin_oe[0] && pin_out[0] == $past(pwm_a_in))
        else $error("pin 0 not carrying PWM A");
    a_pwm_b_route: assert property (st_reg.func_reg[FBP_FN_PWM_B] |=>
            pin_oe[1] && pin_out[1] == $past(pwm_b_in))
        else $error("pin 1 not carrying PWM B");
    a_pin3_plain: assert property (##1 pin_oe[3] == $past(st_reg.dir_reg[3]))
        else $error("pin 3 drive not set by direction");
    a_write_func: assert property (write_ph && sel_idx == FBP_IDX_FUNC |=>
            st_reg.func_reg == $past(pwdata[3:0]) ##1 pin_oe[2] == 1'b0 || !st_reg.func_reg[2])
        else $error("function write not taken");

    // Write setup followed by its access cycle, with the target register named
    sequence s_write_reg(logic [1:0] idx);
        psel && !penable && pwrite && sel_idx == idx ##1 psel && penable;
    endsequence
    // Read of the function register, setup then access
    sequence s_read_func;
        psel && !penable && !pwrite && sel_idx == FBP_IDX_FUNC ##1 psel && penable;
    endsequence
    // Any read of a mapped register
    sequence s_read_any;
        psel && !penable && !pwrite && sel_idx != FBP_IDX_NONE ##1 psel && penable;
    endsequence
    // Any transfer to an address outside the map
    sequence s_unmapped;
        psel && !penable && sel_idx == FBP_IDX_NONE ##1 psel && penable;
    endsequence
    // Any transfer to a mapped register
    sequence s_mapped;
        psel && !penable && sel_idx != FBP_IDX_NONE ##1 psel && penable;
    endsequence

    // Each write lands in its own register and nowhere else; a stray write
    // to a neighbour would silently flip pin ownership
    a_data_write_lands: assert property (s_write_reg(FBP_IDX_DATA) |=>
            st_reg.data_reg == $past(pwdata[3:0]))
        else $error("data write not stored");
    a_data_write_alone: assert property (s_write_reg(FBP_IDX_DATA) |=>
            st_reg.dir_reg == $past(st_reg.dir_reg) && st_reg.func_reg == $past(st_reg.func_reg))
        else $error("data write disturbed another register");
    a_dir_write_lands: assert property (s_write_reg(FBP_IDX_DIR) |=>
            st_reg.dir_reg == $past(pwdata[3:0]))
        else $error("direction write not stored");
    a_dir_write_alone: assert property (s_write_reg(FBP_IDX_DIR) |=>
            st_reg.data_reg == $past(st_reg.data_reg) && st_reg.func_reg == $past(st_reg.func_reg))
        else $error("direction write disturbed another register");
    a_func_write_alone: assert property (s_write_reg(FBP_IDX_FUNC) |=>
            st_reg.data_reg == $past(st_reg.data_reg) && st_reg.dir_reg == $past(st_reg.dir_reg))
        else $error("function write disturbed another register");

    // The spare function bit is plain storage: software is asked to keep it
    // at 0, but the hardware still keeps and returns whatever arrives
    a_func_spare_kept: assert property (s_write_reg(FBP_IDX_FUNC) |=>
            st_reg.func_reg[FBP_FN_SPARE] == $past(pwdata[FBP_FN_SPARE]))
        else $error("spare function bit not stored");
    a_func_read_back: assert property (s_read_func |->
            prdata == {24'h000000, FBP_UPPER_ONES, $past(st_reg.func_reg)})
        else $error("function read wrong");

    // Reads have no side effects on the stored settings
    a_read_no_change: assert property (s_read_any |=>
            st_reg.data_reg == $past(st_reg.data_reg) && st_reg.dir_reg == $past(st_reg.dir_reg)
            && st_reg.func_reg == $past(st_reg.func_reg))
        else $error("read changed a register");

    // Read data and error flag only move at a setup edge, so a slow master
    // still sees the answer of its own transfer
    a_rdata_holds: assert property (!(psel && !penable) |=> prdata == $past(prdata) && pslverr == $past(pslverr))
        else $error("read data moved outside a setup cycle");

    // Unmapped transfers are refused; mapped ones never are
    a_unmapped_err: assert property (s_unmapped |-> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");
    a_mapped_no_err: assert property (s_mapped |-> !pslverr)
        else $error("mapped access flagged as error");
    a_unmapped_no_write: assert property (s_write_reg(FBP_IDX_NONE) |=>
            st_reg.data_reg == $past(st_reg.data_reg) && st_reg.dir_reg == $past(st_reg.dir_reg)
            && st_reg.func_reg == $past(st_reg.func_reg))
        else $error("unmapped write changed a register");

    // Pins 1, 2 and 3 follow their port settings while they are general-purpose
    a_gpio_drive_pin1: assert property (!st_reg.func_reg[FBP_FN_PWM_B] |=>
            pin_oe[1] == $past(st_reg.dir_reg[1]) && (!pin_oe[1] || pin_out[1] == $past(st_reg.data_reg[1])))
        else $error("pin 1 general-purpose drive wrong");
    a_gpio_drive_pin2: assert property (!st_reg.func_reg[FBP_FN_IRQ] |=>
            pin_oe[2] == $past(st_reg.dir_reg[2]) && (!pin_oe[2] || pin_out[2] == $past(st_reg.data_reg[2])))
        else $error("pin 2 general-purpose drive wrong");
    a_pin3_data: assert property (##1 !pin_oe[3] || pin_out[3] == $past(st_reg.data_reg[3]))
        else $error("pin 3 drive value wrong");

    // The interrupt controller sees nothing while pin 2 is general-purpose,
    // so a toggling output pin cannot raise spurious requests
    a_irq_idle_low: assert property (!st_reg.func_reg[FBP_FN_IRQ] |=> !ext_irq_out)
        else $error("interrupt output active while pin 2 is general-purpose");

    // Second synchroniser stage copies the first and nothing else
    a_sync_chain: assert property (##1 st_reg.sync2_reg == $past(st_reg.sync1_reg))
        else $error("pin synchroniser stage skipped");

endmodule // fbp_port

/* File: core/fbp_pkg.sv */
/*
 Constants for the four-pin port: register offsets, field positions and reset values.
 Assumes an APB master with 32-bit data and word-aligned byte addresses.
*/
package fbp_pkg;
    // Byte offsets of the registers
    localparam logic [7:0] FBP_OFF_DATA = 8'h00;
    localparam logic [7:0] FBP_OFF_DIR = 8'h04;
    localparam logic [7:0] FBP_OFF_FUNC = 8'h08;
    // Register index returned by the decoder
    localparam logic [1:0] FBP_IDX_DATA = 2'h0;
    localparam logic [1:0] FBP_IDX_DIR = 2'h1;
    localparam logic [1:0] FBP_IDX_FUNC = 2'h2;
    localparam logic [1:0] FBP_IDX_NONE = 2'h3;
    // Reset values of the stored fields
    localparam logic [3:0] FBP_DATA_RST = 4'hF;
    localparam logic [3:0] FBP_DIR_RST = 4'h0;
    localparam logic [3:0] FBP_FUNC_RST = 4'h0;
    // Fixed read-back patterns
    localparam logic [3:0] FBP_UPPER_ONES = 4'hF;
    localparam logic [7:0] FBP_DIR_READ = 8'hFF;
    // Function register bit positions
    localparam int FBP_FN_PWM_A = 0;
    localparam int FBP_FN_PWM_B = 1;
    localparam int FBP_FN_IRQ = 2;
    localparam int FBP_FN_SPARE = 3;
    // Pin numbers with alternate functions, and the one plain pin
    localparam int FBP_PIN_PWM_A = 0;
    localparam int FBP_PIN_PWM_B = 1;
    localparam int FBP_PIN_IRQ = 2;
    localparam int FBP_PIN_PLAIN = 3;
endpackage

/* File: tb/fbp_board.sv */
/*
 Board and PWM timer model facing the four port pins.
 Assumes pclk-synchronous timers and a board pulling released pins to pull_lvl.
*/
`timescale 1ns/10ps
module fbp_board (
    input wire logic pclk,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] pull_lvl,
    input wire logic [1:0] pwm_lvl,
    output logic [3:0] pin_in,
    output logic pwm_a_in,
    output logic pwm_b_in
);
    // Driven pins show their drive; released pins fall to the board pull, never hold a stale value
    assign pin_in = (pin_out & pin_oe) | (pull_lvl & ~pin_oe);
    // Timers launch on pclk, as the on-chip PWM units would
    always_ff @(posedge pclk) begin
        pwm_a_in <= pwm_lvl[0];
        pwm_b_in <= pwm_lvl[1];
    end
endmodule // fbp_board

/* File: tb/test_four_bit_port_with_irq_pwm_mux.sv */
/*
 Self-checking bench for the four-pin port: APB register access, pins, PWM and interrupt hand-off.
 Assumes fbp_pkg offsets and the board model in fbp_board.
*/
`timescale 1ns/10ps
module test_four_bit_port_with_irq_pwm_mux;
    import fbp_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, pwm_a_in, pwm_b_in, ext_irq_out, err;
    logic [3:0] pin_in, pin_out, pin_oe, pull_lvl = 4'h6;
    logic [1:0] pwm_lvl = 2'h0;
    int failures = 0, checks_done = 0;
    // Free-running 20 MHz clock
    always #25 pclk = ~pclk;
    fbp_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pwm_a_in(pwm_a_in), .pwm_b_in(pwm_b_in),
        .ext_irq_out(ext_irq_out));
    fbp_board board (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_lvl(pull_lvl),
        .pwm_lvl(pwm_lvl), .pin_in(pin_in), .pwm_a_in(pwm_a_in), .pwm_b_in(pwm_b_in));
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; request held until pready is sampled high, data taken at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            failures++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Pins settle through the two-flop synchroniser plus one output flop
    task automatic pins(input logic [7:0] exp);
        repeat (5) @(posedge pclk);
        chk({24'h0, pin_oe, pin_out & pin_oe}, {24'h0, exp});
    endtask
    task automatic t_reset;
        repeat (4) @(posedge pclk);
        apb(1'b0, FBP_OFF_DIR, 32'h0);
        chk(rd, 32'h000000FF);
        apb(1'b0, FBP_OFF_FUNC, 32'h0);
        chk(rd, 32'h000000F0);
        apb(1'b0, FBP_OFF_DATA, 32'h0);
        chk(rd, 32'h000000F6);
        pins(8'h00);
    endtask
    task automatic t_gpio;
        apb(1'b1, FBP_OFF_DIR, 32'h000000F3);
        apb(1'b1, FBP_OFF_DATA, 32'h000000A9);
        pins(8'h31);
        apb(1'b0, FBP_OFF_DATA, 32'h0);
        chk(rd, 32'h000000F5);
        apb(1'b1, FBP_OFF_DIR, 32'h00000008);
        pins(8'h88);
        apb(1'b0, FBP_OFF_DATA, 32'h0);
        chk(rd, 32'h000000FE);
    endtask
    // Pin 2 direction kept at 0 while it serves the interrupt input
    task automatic t_func;
        pwm_lvl <= 2'b01;
        apb(1'b1, FBP_OFF_DATA, 32'h00000002);
        apb(1'b1, FBP_OFF_DIR, 32'h00000003);
        apb(1'b1, FBP_OFF_FUNC, 32'h00000007);
        pins(8'h31);
        chk({31'h0, ext_irq_out}, 32'h1);
        apb(1'b0, FBP_OFF_DATA, 32'h0);
        chk(rd, 32'h000000F6);
        apb(1'b0, FBP_OFF_FUNC, 32'h0);
        chk(rd, 32'h000000F7);
        apb(1'b1, FBP_OFF_DIR, 32'h00000000);
        pull_lvl <= 4'h2;
        pwm_lvl <= 2'b10;
        pins(8'h32);
        chk({31'h0, ext_irq_out}, 32'h0);
        apb(1'b0, FBP_OFF_DATA, 32'h0);
        chk(rd, 32'h000000F2);
    endtask
    task automatic t_unmapped;
        apb(1'b0, 8'h0C, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, 8'h0C, 32'h000000FF);
        apb(1'b0, FBP_OFF_FUNC, 32'h0);
        chk(rd, 32'h000000F7);
    endtask
    // Reset held for ten cycles, then the scenarios in turn
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_gpio();
        t_func();
        t_unmapped();
        give_verdict();
    end
endmodule // test_four_bit_port_with_irq_pwm_mux
